// ===== pkg/htcfg_pkg.sv
// Purpose: Shared constants and types of the transmitter config block
// Assumes: 32-bit AXI4-Lite, one register per aligned word
// Notes:   Register indices kept as printed; byte address is four times
package htcfg_pkg;

  // Register indices and their byte addresses
  localparam logic [7:0] IDX_TXCTRL  = 8'h0E;
  localparam logic [7:0] IDX_TMO_LO  = 8'h10;
  localparam logic [7:0] IDX_TMO_HI  = 8'h11;
  localparam logic [7:0] IDX_STATUS  = 8'h12;
  localparam logic [7:0] ADR_TXCTRL  = {IDX_TXCTRL[5:0], 2'b00};
  localparam logic [7:0] ADR_TMO_LO  = {IDX_TMO_LO[5:0], 2'b00};
  localparam logic [7:0] ADR_TMO_HI  = {IDX_TMO_HI[5:0], 2'b00};
  localparam logic [7:0] ADR_STATUS  = {IDX_STATUS[5:0], 2'b00};

  // Field positions of the control register
  localparam int unsigned SWING_LSB = 4;
  localparam int unsigned PRE_LSB   = 0;

  // Field encodings
  localparam logic [1:0] SWING_180 = 2'h0;
  localparam logic [1:0] SWING_200 = 2'h1;
  localparam logic [1:0] SWING_220 = 2'h2;
  localparam logic [1:0] PRE_1P5   = 2'h0;
  localparam logic [1:0] PRE_0     = 2'h1;
  localparam logic [1:0] PRE_2P5   = 2'h2;

  // Values after reset
  localparam logic [1:0]  FIELD_RST = 2'h0;
  localparam logic [7:0]  TMO_RST   = 8'hFF;
  localparam logic [15:0] TMO_WORD_RST = {TMO_RST, TMO_RST};

  // Status bit positions
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_ABORT   = 1;
  localparam int unsigned STAT_ACK     = 2;
  localparam int unsigned STAT_PENDING = 3;

  // Bit positions of the events crossing from the link domain
  localparam int unsigned EV_BUSY  = 0;
  localparam int unsigned EV_ABORT = 1;
  localparam int unsigned EV_ACK   = 2;
  localparam int unsigned EV_LOAD  = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE, SEL_TXCTRL, SEL_TMO_LO, SEL_TMO_HI, SEL_STATUS
  } htcfg_sel_t;

  typedef enum logic {TMR_IDLE = 1'b0, TMR_RUN = 1'b1} htcfg_tmr_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } htcfg_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } htcfg_axil_rsp_t;

  typedef logic [3:0] htcfg_evt_t;

endpackage

// ===== logic/htcfg_turn_timer.sv
// Purpose: Turnaround timeout counter on the low-power transmitter clock
// Assumes: turn_request and turn_ack are synchronous to clk_lp
// Notes:   Timeout word arrives by toggle handshake from clk_sys
`timescale 1ns/1ps
module htcfg_turn_timer
(
  input  wire logic                 clk_lp,
  input  wire logic                 rstn,
  input  wire logic                 ce,
  input  wire logic                 turn_request,
  input  wire logic                 turn_ack,
  input  wire logic                 tmo_req_tgl,
  input  wire logic [15:0]          tmo_shadow,
  output htcfg_pkg::htcfg_evt_t     evt,
  output logic                      turn_abort
);

  logic [1:0]                  rst_sync;
  logic [1:0]                  ce_sync;
  logic [2:0]                  tgl_sync;
  logic                        lp_rstn;
  logic                        ce_lp;
  logic [15:0]                 tmo_lp;
  logic [15:0]                 count;
  htcfg_pkg::htcfg_tmr_state_t state;
  logic                        abort_tgl;
  logic                        ack_tgl;
  logic                        load_tgl;
  logic                        expire;

  // Reset and clock enable brought into this domain
  always_ff @(posedge clk_lp)
  begin
    rst_sync <= {rst_sync[0], rstn};
  end
  assign lp_rstn = rst_sync[1];

  always_ff @(posedge clk_lp)
  begin
    if (!lp_rstn)
      ce_sync <= 2'h0;
    else
      ce_sync <= {ce_sync[0], ce};
  end
  assign ce_lp = ce_sync[1];

  // Timeout word capture; third stage frozen so no edge is lost
  always_ff @(posedge clk_lp)
  begin
    if (!lp_rstn)
    begin
      tgl_sync <= 3'h0;
      tmo_lp   <= htcfg_pkg::TMO_WORD_RST;
      load_tgl <= 1'b0;
    end
    else
    begin
      tgl_sync[1:0] <= {tgl_sync[0], tmo_req_tgl};
      if (ce_lp)
      begin
        tgl_sync[2] <= tgl_sync[1];
        if (tgl_sync[1] ^ tgl_sync[2])
        begin
          tmo_lp   <= tmo_shadow;
          load_tgl <= tgl_sync[1];
        end
      end
    end
  end

  assign expire = (state == htcfg_pkg::TMR_RUN) && !turn_request && !turn_ack
                  && (count == tmo_lp);

  // Timer; a new request restarts it even while running
  always_ff @(posedge clk_lp)
  begin
    if (!lp_rstn)
    begin
      state      <= htcfg_pkg::TMR_IDLE;
      count      <= 16'h0000;
      abort_tgl  <= 1'b0;
      ack_tgl    <= 1'b0;
      turn_abort <= 1'b0;
    end
    else if (ce_lp)
    begin
      turn_abort <= expire;
      if (turn_request)
      begin
        state <= htcfg_pkg::TMR_RUN;
        count <= 16'h0000;
      end
      else if (state == htcfg_pkg::TMR_RUN)
      begin
        unique case (1'b1)
          turn_ack:
          begin
            state   <= htcfg_pkg::TMR_IDLE;
            ack_tgl <= ~ack_tgl;
          end
          expire:
          begin
            state     <= htcfg_pkg::TMR_IDLE;
            abort_tgl <= ~abort_tgl;
          end
          default:
            count <= count + 16'h0001;
        endcase
      end
    end
  end

  // Events handed to the system domain
  always_comb
  begin
    evt                       = 4'h0;
    evt[htcfg_pkg::EV_BUSY]   = (state == htcfg_pkg::TMR_RUN);
    evt[htcfg_pkg::EV_ABORT]  = abort_tgl;
    evt[htcfg_pkg::EV_ACK]    = ack_tgl;
    evt[htcfg_pkg::EV_LOAD]   = load_tgl;
  end

endmodule // htcfg_turn_timer

// ===== logic/htcfg_top.sv
// Purpose: Transmitter swing/pre-emphasis and turnaround timeout registers
// Assumes: AXI4-Lite master on clk_sys; far end synchronous to clk_lp
// Notes:   Counter lives in htcfg_turn_timer on clk_lp
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module htcfg_top
(
  input  wire logic                      clk_sys,
  input  wire logic                      rstn,
  input  wire logic                      ce,
  input  wire logic                      clk_lp,
  input  wire logic                      strap_pin_zero,
  input  wire logic                      strap_pin_one,
  input  wire htcfg_pkg::htcfg_axil_req_t axil_req,
  output htcfg_pkg::htcfg_axil_rsp_t     axil_rsp,
  input  wire logic                      turn_request,
  input  wire logic                      turn_ack,
  output logic                           turn_abort,
  output logic [1:0]                     tx_swing_level,
  output logic [1:0]                     tx_preemphasis_level
);

  logic [1:0]              strap_s1;
  logic [1:0]              strap_s2;
  logic                    strap_loaded;
  htcfg_pkg::htcfg_evt_t   evt;
  htcfg_pkg::htcfg_evt_t   ev_s1;
  htcfg_pkg::htcfg_evt_t   ev_s2;
  htcfg_pkg::htcfg_evt_t   ev_s3;
  logic                    busy_s;
  logic                    abort_ev;
  logic                    ack_ev;
  logic                    hs_idle;
  logic [7:0]              turnaround_timeout_low_byte;
  logic [7:0]              turnaround_timeout_high_byte;
  logic                    abort_seen;
  logic                    ack_seen;
  logic                    tmo_dirty;
  logic                    tmo_req_tgl;
  logic [15:0]             tmo_shadow;
  logic                    aw_held;
  logic [7:0]              aw_addr;
  logic                    w_held;
  logic [31:0]             w_data;
  logic [3:0]              w_strb;
  logic                    bvalid;
  logic [1:0]              bresp;
  logic                    rvalid;
  logic [31:0]             rdata;
  logic [1:0]              rresp;
  logic                    awready;
  logic                    wready;
  logic                    arready;
  logic                    do_write;
  logic                    lane0;
  htcfg_pkg::htcfg_sel_t   wsel;
  htcfg_pkg::htcfg_sel_t   rsel;
  logic                    clr_abort;
  logic                    clr_ack;

  // Word address decode, shared by both channels
  function automatic htcfg_pkg::htcfg_sel_t decode(input logic [7:0] addr);
    decode = htcfg_pkg::SEL_NONE;
    unique case (addr[7:2])
      htcfg_pkg::ADR_TXCTRL[7:2]: decode = htcfg_pkg::SEL_TXCTRL;
      htcfg_pkg::ADR_TMO_LO[7:2]: decode = htcfg_pkg::SEL_TMO_LO;
      htcfg_pkg::ADR_TMO_HI[7:2]: decode = htcfg_pkg::SEL_TMO_HI;
      htcfg_pkg::ADR_STATUS[7:2]: decode = htcfg_pkg::SEL_STATUS;
      default:                    decode = htcfg_pkg::SEL_NONE;
    endcase
  endfunction

  // Two-level straps: any high strap gives the top swing
  function automatic logic [1:0] swing_from_straps(input logic [1:0] s);
    swing_from_straps = (s[0] | s[1]) ? htcfg_pkg::SWING_220
                                      : htcfg_pkg::SWING_200;
  endfunction

  function automatic logic [1:0] pre_from_strap(input logic s1);
    pre_from_strap = s1 ? htcfg_pkg::PRE_2P5 : htcfg_pkg::PRE_0;
  endfunction

  // Strap pins are asynchronous levels; the pair keeps running through
  // reset so settled strap levels are waiting when the fields load
  always_ff @(posedge clk_sys)
  begin
    strap_s1 <= {strap_pin_one, strap_pin_zero};
    strap_s2 <= strap_s1;
  end

  // Link events: level for busy, toggles for the rest
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ev_s1 <= 4'h0;
      ev_s2 <= 4'h0;
      ev_s3 <= 4'h0;
    end
    else
    begin
      ev_s1 <= evt;
      ev_s2 <= ev_s1;
      if (ce)
        ev_s3 <= ev_s2;
    end
  end

  assign busy_s   = ev_s2[htcfg_pkg::EV_BUSY];
  assign abort_ev = ev_s2[htcfg_pkg::EV_ABORT] ^ ev_s3[htcfg_pkg::EV_ABORT];
  assign ack_ev   = ev_s2[htcfg_pkg::EV_ACK] ^ ev_s3[htcfg_pkg::EV_ACK];
  assign hs_idle  = (ev_s2[htcfg_pkg::EV_LOAD] == tmo_req_tgl);

  // Bus handshakes; one write and one read in flight at most
  assign awready  = ce && !aw_held && !bvalid;
  assign wready   = ce && !w_held && !bvalid;
  assign arready  = ce && !rvalid;
  assign do_write = ce && aw_held && w_held && !bvalid;
  assign wsel     = decode(aw_addr);
  assign rsel     = decode(axil_req.araddr);
  assign lane0    = w_strb[0];

  // Address and data taken in either order
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else if (ce)
    begin
      if (axil_req.awvalid && awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= axil_req.awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (axil_req.wvalid && wready)
      begin
        w_held <= 1'b1;
        w_data <= axil_req.wdata;
        w_strb <= axil_req.wstrb;
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  // Write response; unmapped addresses answer with an error
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      bvalid <= 1'b0;
      bresp  <= htcfg_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (do_write)
      begin
        bvalid <= 1'b1;
        bresp  <= (wsel == htcfg_pkg::SEL_NONE) ? htcfg_pkg::RESP_SLVERR
                                                : htcfg_pkg::RESP_OKAY;
      end
      else if (axil_req.bready)
        bvalid <= 1'b0;
    end
  end

  // Fields start at zero, then take the strap levels once after release
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      strap_loaded         <= 1'b0;
      tx_swing_level       <= htcfg_pkg::FIELD_RST;
      tx_preemphasis_level <= htcfg_pkg::FIELD_RST;
    end
    else if (ce)
    begin
      if (!strap_loaded)
      begin
        strap_loaded         <= 1'b1;
        tx_swing_level       <= swing_from_straps(strap_s2);
        tx_preemphasis_level <= pre_from_strap(strap_s2[1]);
      end
      else if (do_write && lane0 && wsel == htcfg_pkg::SEL_TXCTRL)
      begin
        // Reserved bits 7:6 and 3:2 dropped here
        tx_swing_level       <= w_data[htcfg_pkg::SWING_LSB +: 2];
        tx_preemphasis_level <= w_data[htcfg_pkg::PRE_LSB +: 2];
      end
    end
  end

  // Timeout bytes; any change marks the word for transfer
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      turnaround_timeout_low_byte  <= htcfg_pkg::TMO_RST;
      turnaround_timeout_high_byte <= htcfg_pkg::TMO_RST;
    end
    else if (do_write && lane0)
    begin
      if (wsel == htcfg_pkg::SEL_TMO_LO)
        turnaround_timeout_low_byte <= w_data[7:0];
      if (wsel == htcfg_pkg::SEL_TMO_HI)
        turnaround_timeout_high_byte <= w_data[7:0];
    end
  end

  // Shadow stays still while a transfer is in flight; a write wins over send
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      tmo_dirty   <= 1'b0;
      tmo_req_tgl <= 1'b0;
      tmo_shadow  <= htcfg_pkg::TMO_WORD_RST;
    end
    else if (ce)
    begin
      if (do_write && lane0 && (wsel == htcfg_pkg::SEL_TMO_LO
                                || wsel == htcfg_pkg::SEL_TMO_HI))
        tmo_dirty <= 1'b1;
      else if (tmo_dirty && hs_idle)
        tmo_dirty <= 1'b0;
      if (tmo_dirty && hs_idle)
      begin
        tmo_shadow  <= {turnaround_timeout_high_byte,
                        turnaround_timeout_low_byte};
        tmo_req_tgl <= ~tmo_req_tgl;
      end
    end
  end

  // Sticky outcome flags, cleared by writing one; a new event wins
  assign clr_abort = do_write && lane0 && wsel == htcfg_pkg::SEL_STATUS
                     && w_data[htcfg_pkg::STAT_ABORT];
  assign clr_ack   = do_write && lane0 && wsel == htcfg_pkg::SEL_STATUS
                     && w_data[htcfg_pkg::STAT_ACK];

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      abort_seen <= 1'b0;
      ack_seen   <= 1'b0;
    end
    else if (ce)
    begin
      abort_seen <= abort_ev || (abort_seen && !clr_abort);
      ack_seen   <= ack_ev || (ack_seen && !clr_ack);
    end
  end

  // Read data captured at the address edge
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= htcfg_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (axil_req.arvalid && arready)
      begin
        rvalid <= 1'b1;
        rresp  <= htcfg_pkg::RESP_OKAY;
        rdata  <= 32'h0000_0000;
        unique case (rsel)
          htcfg_pkg::SEL_TXCTRL:
            rdata[7:0] <= {2'h0, tx_swing_level,
                           2'h0, tx_preemphasis_level};
          htcfg_pkg::SEL_TMO_LO:
            rdata[7:0] <= turnaround_timeout_low_byte;
          htcfg_pkg::SEL_TMO_HI:
            rdata[7:0] <= turnaround_timeout_high_byte;
          htcfg_pkg::SEL_STATUS:
          begin
            rdata[htcfg_pkg::STAT_BUSY]    <= busy_s;
            rdata[htcfg_pkg::STAT_ABORT]   <= abort_seen;
            rdata[htcfg_pkg::STAT_ACK]     <= ack_seen;
            rdata[htcfg_pkg::STAT_PENDING] <= tmo_dirty || !hs_idle;
          end
          default:
            rresp <= htcfg_pkg::RESP_SLVERR;
        endcase
      end
      else if (axil_req.rready)
        rvalid <= 1'b0;
    end
  end

  // Response bundle
  always_comb
  begin
    axil_rsp         = '0;
    axil_rsp.awready = awready;
    axil_rsp.wready  = wready;
    axil_rsp.bvalid  = bvalid;
    axil_rsp.bresp   = bresp;
    axil_rsp.arready = arready;
    axil_rsp.rvalid  = rvalid;
    axil_rsp.rdata   = rdata;
    axil_rsp.rresp   = rresp;
  end

  // Link-side counter on the low-power transmitter clock
  htcfg_turn_timer u_timer
  (
    .clk_lp       (clk_lp),
    .rstn         (rstn),
    .ce           (ce),
    .turn_request (turn_request),
    .turn_ack     (turn_ack),
    .tmo_req_tgl  (tmo_req_tgl),
    .tmo_shadow   (tmo_shadow),
    .evt          (evt),
    .turn_abort   (turn_abort)
  );

endmodule // htcfg_top

// ===== testbench/htcfg_top_chk.sv
// Purpose: Port assertions for htcfg_top
// Assumes: Timeout programmed above zero while link traffic runs
// Notes:   Link checks sample on clk_lp
`timescale 1ns/1ps
module htcfg_top_chk
(
  input wire logic                       clk_sys,
  input wire logic                       rstn,
  input wire logic                       ce,
  input wire logic                       clk_lp,
  input wire logic                       strap_pin_zero,
  input wire logic                       strap_pin_one,
  input wire htcfg_pkg::htcfg_axil_req_t axil_req,
  input wire htcfg_pkg::htcfg_axil_rsp_t axil_rsp,
  input wire logic                       turn_request,
  input wire logic                       turn_ack,
  input wire logic                       turn_abort,
  input wire logic [1:0]                 tx_swing_level,
  input wire logic [1:0]                 tx_preemphasis_level
);
  logic [7:0] rd_a;
  logic       ctl;
  logic       mapped;
  // Address of the read in flight, so rdata can be judged
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      rd_a <= 8'h00;
    else if (ce && axil_req.arvalid && axil_rsp.arready)
      rd_a <= axil_req.araddr;
  end
  // Decode of the captured address
  assign ctl    = axil_rsp.rvalid && (rd_a[7:2] == htcfg_pkg::ADR_TXCTRL[7:2]);
  assign mapped = rd_a[7:2] inside {6'h0E, 6'h10, 6'h11, 6'h12};

  a_ctrl_rsvd: assert property (@(posedge clk_sys) disable iff (!rstn)
    ctl |-> axil_rsp.rdata[31:6] == '0 && axil_rsp.rdata[3:2] == 2'h0) else $error("rsvd bits");
  a_ctrl_mirror: assert property (@(posedge clk_sys) disable iff (!rstn)
    ctl |-> axil_rsp.rdata[5:4] == tx_swing_level && axil_rsp.rdata[1:0] == tx_preemphasis_level)
    else $error("ctrl readback differs from pins");
  a_swing_strap: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(rstn) && ce |=> tx_swing_level == ((strap_pin_zero || strap_pin_one) ? 2'h2 : 2'h1))
    else $error("swing not strap");
  a_pre_strap: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(rstn) && ce |=> tx_preemphasis_level == (strap_pin_one ? 2'h2 : 2'h1))
    else $error("pre not strap");
  a_write_resp: assert property (@(posedge clk_sys) disable iff (!rstn)
    ce && axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
    |-> ##2 axil_rsp.bvalid) else $error("no write response");
  a_read_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    axil_rsp.rvalid && !axil_req.rready |=> axil_rsp.rvalid && $stable(axil_rsp.rdata))
    else $error("read data dropped");
  a_unmapped_err: assert property (@(posedge clk_sys) disable iff (!rstn)
    axil_rsp.rvalid && !mapped |-> axil_rsp.rresp == htcfg_pkg::RESP_SLVERR
    && axil_rsp.rdata == '0) else $error("unmapped read");
  a_abort_pulse: assert property (@(posedge clk_lp) disable iff (!rstn)
    turn_abort |=> !turn_abort) else $error("abort longer than one cycle");
  a_ack_stops: assert property (@(posedge clk_lp) disable iff (!rstn)
    turn_ack && !turn_request |=> !turn_abort) else $error("abort after ack");
  a_req_restart: assert property (@(posedge clk_lp) disable iff (!rstn)
    turn_request |=> !turn_abort) else $error("abort right after request");
endmodule // htcfg_top_chk

bind htcfg_top htcfg_top_chk u_chk
(
  .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .clk_lp(clk_lp),
  .strap_pin_zero(strap_pin_zero), .strap_pin_one(strap_pin_one),
  .axil_req(axil_req), .axil_rsp(axil_rsp), .turn_request(turn_request),
  .turn_ack(turn_ack), .turn_abort(turn_abort), .tx_swing_level(tx_swing_level),
  .tx_preemphasis_level(tx_preemphasis_level)
);

// ===== testbench/htcfg_far_end.sv
// Purpose: Far end that requests and acknowledges turnarounds
// Assumes: Driven on clk_lp rising edges
// Notes:   Returns the edge of abort counted from the request edge
`timescale 1ns/1ps
module htcfg_far_end
(
  input  wire logic clk_lp,
  input  wire logic turn_abort,
  output logic      turn_request,
  output logic      turn_ack
);
  // Idle lines at time zero
  initial
  begin
    turn_request = 1'b0;
    turn_ack     = 1'b0;
  end
  // Edge 0 samples the request; re_at and ack_at are edges after it, lat is -1 if none
  task automatic bta(input int re_at, input int ack_at, output int lat);
    int n;
    lat = -1;
    @(posedge clk_lp);
    turn_request <= 1'b1;
    for (n = 0; n < 400; n++)
    begin
      @(posedge clk_lp);
      turn_request <= (n == re_at);
      turn_ack     <= (n == ack_at);
      #1;
      if (turn_abort === 1'b1 && lat < 0)
        lat = n;
    end
  endtask
endmodule // htcfg_far_end

// ===== testbench/test_hstx_cfg_and_turnaround_timeout.sv
// Purpose: Self-checking bench for htcfg_top
// Assumes: ce held high; clk_lp 30 ns unrelated to clk_sys
// Notes:   Timeout is programmed small to keep the run short
`timescale 1ns/1ps
module test_hstx_cfg_and_turnaround_timeout;
  logic                       clk_sys;
  logic                       clk_lp;
  logic                       rstn;
  logic                       ce;
  logic                       strap0;
  logic                       strap1;
  htcfg_pkg::htcfg_axil_req_t req;
  htcfg_pkg::htcfg_axil_rsp_t rsp;
  logic                       turn_request;
  logic                       turn_ack;
  logic                       turn_abort;
  logic [1:0]                 swing;
  logic [1:0]                 pre;
  logic [31:0]                rd;
  logic [1:0]                 rr;
  int                         err_count;
  int                         tests_run;

  htcfg_top dut
  (
    .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .clk_lp(clk_lp),
    .strap_pin_zero(strap0), .strap_pin_one(strap1), .axil_req(req), .axil_rsp(rsp),
    .turn_request(turn_request), .turn_ack(turn_ack), .turn_abort(turn_abort),
    .tx_swing_level(swing), .tx_preemphasis_level(pre)
  );
  htcfg_far_end far
  (
    .clk_lp(clk_lp), .turn_abort(turn_abort), .turn_request(turn_request),
    .turn_ack(turn_ack)
  );

  // Clocks; lp phase offset keeps edges apart
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    clk_lp = 1'b0;
    #7;
    forever #15 clk_lp = ~clk_lp;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Write; valid held until each ready is sampled high
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    // Only the watchdog ends a wait
    do
    begin
      @(posedge clk_sys);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
    end
    while (!rsp.bvalid);
    rr = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  // Read; rready raised one cycle late so the held read data is exercised
  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    do
    begin
      @(posedge clk_sys);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid)
        req.rready <= 1'b1;
    end
    while (!(req.rready && rsp.rvalid));
    rd = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  // Every strap combination, then reset contents
  task automatic t_straps();
    logic [1:0] i;
    logic [1:0] es;
    logic [1:0] ep;
    for (int k = 0; k < 4; k++)
    begin
      i = k[1:0];
      es = (i != 2'h0) ? 2'h2 : 2'h1;
      ep = i[1] ? 2'h2 : 2'h1;
      @(posedge clk_sys);
      rstn   <= 1'b0;
      strap0 <= i[0];
      strap1 <= i[1];
      repeat (5) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (3) @(posedge clk_sys);
      chk("swing", {30'h0, es}, {30'h0, swing});
      chk("pre", {30'h0, ep}, {30'h0, pre});
      rd_reg(htcfg_pkg::ADR_TXCTRL);
      chk("ctrl", {26'h0, es, 2'h0, ep}, rd);
      rd_reg(htcfg_pkg::ADR_TMO_LO);
      chk("tmo lo", 32'h0000_00FF, rd);
      rd_reg(htcfg_pkg::ADR_TMO_HI);
      chk("tmo hi", 32'h0000_00FF, rd);
    end
  endtask

  // All codes of both fields with reserved bits set, then refused accesses
  task automatic t_fields();
    logic [1:0] v;
    for (int k = 0; k < 4; k++)
    begin
      v = k[1:0];
      wr(htcfg_pkg::ADR_TXCTRL, {24'hFFFF_FF, 2'h3, v, 2'h3, ~v}, 4'hF);
      chk("swing code", {30'h0, v}, {30'h0, swing});
      chk("pre code", {30'h0, ~v}, {30'h0, pre});
      rd_reg(htcfg_pkg::ADR_TXCTRL);
      chk("ctrl rsvd", {26'h0, v, 2'h0, ~v}, rd);
    end
    wr(htcfg_pkg::ADR_TXCTRL, 32'h0000_0000, 4'h0);
    chk("no strobe", 32'h0000_0030, {26'h0, swing, 2'h0, pre});
    rd_reg(8'h3C);
    chk("unmapped rresp", {30'h0, htcfg_pkg::RESP_SLVERR}, {30'h0, rr});
    wr(8'h3C, 32'h0000_0001, 4'hF);
    chk("unmapped bresp", {30'h0, htcfg_pkg::RESP_SLVERR}, {30'h0, rr});
  endtask

  // Timeout on the link clock: expiry, ack, restart, high byte weight
  task automatic t_timeout();
    int lat;
    wr(htcfg_pkg::ADR_TMO_HI, 32'h0000_0000, 4'hF);
    wr(htcfg_pkg::ADR_TMO_LO, 32'h0000_0005, 4'hF);
    rd_reg(htcfg_pkg::ADR_TMO_LO);
    chk("tmo lo rw", 32'h0000_0005, rd);
    repeat (20) @(posedge clk_sys);
    far.bta(999, 999, lat);
    chk("abort edge", 32'd6, lat);
    far.bta(999, 2, lat);
    chk("ack no abort", 32'hFFFF_FFFF, lat);
    rd_reg(htcfg_pkg::ADR_STATUS);
    chk("status", 32'h0000_0006, rd);
    far.bta(3, 999, lat);
    chk("restart edge", 32'd10, lat);
    wr(htcfg_pkg::ADR_TMO_HI, 32'h0000_0001, 4'hF);
    wr(htcfg_pkg::ADR_TMO_LO, 32'h0000_0000, 4'hF);
    repeat (20) @(posedge clk_sys);
    far.bta(999, 999, lat);
    chk("16-bit timeout", 32'd257, lat);
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog: run needs about twelve hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    summarize();
  end

  // Main sequence
  initial
  begin
    err_count = 0;
    tests_run = 0;
    rstn      = 1'b0;
    ce        = 1'b1;
    strap0    = 1'b0;
    strap1    = 1'b0;
    req       = '0;
    t_straps();
    t_fields();
    t_timeout();
    summarize();
  end
endmodule // test_hstx_cfg_and_turnaround_timeout
